// ===== src/eqmon_pkg.sv
// Purpose: shared constants and types of the two-channel equivalence monitor
// Assumes: 25 MHz reference clock, APB register access
// Notes: offsets are byte addresses of aligned 32-bit words
package eqmon_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	// default mismatch time, zero means expiry without delay
	localparam int MISMATCH_TIME_NS = 0;
	localparam int MISMATCH_CYCLES = MISMATCH_TIME_NS / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 3;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LIMIT = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_DIAG = 8'h0C;
	localparam int CTRL_ACT_BIT = 0;
	localparam int STS_READY_BIT = 0;
	localparam int STS_OUT_BIT = 1;
	localparam int STS_DEMAND_BIT = 2;
	localparam int STS_ERROR_BIT = 3;
	localparam int STS_FIRST_BIT = 4;
	localparam int STS_SECOND_BIT = 5;
	localparam logic RST_ACT = 1'b0;

	// ------------------------------------------------------------
	// diagnostic words
	// ------------------------------------------------------------
	localparam logic [15:0] DIAG_IDLE = 16'h0000;
	localparam logic [15:0] DIAG_INIT = 16'h8801;
	localparam logic [15:0] DIAG_ENABLED = 16'h8000;
	localparam logic [15:0] DIAG_WAIT_SECOND = 16'h8802;
	localparam logic [15:0] DIAG_WAIT_FIRST = 16'h8804;
	localparam logic [15:0] DIAG_WAIT_DROP = 16'h8806;
	localparam logic [15:0] DIAG_ERR_SECOND = 16'hC010;
	localparam logic [15:0] DIAG_ERR_FIRST = 16'hC020;
	localparam logic [15:0] DIAG_ERR_DROP = 16'hC030;

	typedef enum logic [3:0] {
		EQM_IDLE = 4'b0000,
		EQM_INIT = 4'b0001,
		EQM_ENABLED = 4'b0010,
		EQM_WAIT_SECOND = 4'b0011,
		EQM_WAIT_FIRST = 4'b0100,
		EQM_WAIT_DROP = 4'b0101,
		EQM_ERR_SECOND = 4'b0110,
		EQM_ERR_FIRST = 4'b0111,
		EQM_ERR_DROP = 4'b1000
	} eqm_state_t;

endpackage

// ===== src/eqmon_top.sv
// Purpose: two-channel equivalence monitor with APB register access
// Assumes: contacts are asynchronous pins; software drives activation
// Notes: all outputs are registered
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module eqmon_top import eqmon_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter int LIMIT_W = 24
) (
	input wire logic ref_clk_i, // 25 MHz clock
	input wire logic nrst_i, // async reset, active low
	input wire logic first_contact_in_i, // first contact, high = closed
	input wire logic second_contact_in_i, // second contact, high = closed
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb write
	input wire logic [ADDR_W-1:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error on unmapped address
	output logic combined_safe_out_o, // combined safety output
	output logic ready_o, // block active
	output logic safe_request_flag_o, // safety demand
	output logic error_o, // error flag
	output logic [15:0] diagnostic_word_o // diagnostic code
);
	import eqmon_pkg::*;

	// ------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------
	if (ADDR_W < 8) begin : g_chk_addr
		$error("ADDR_W must be at least 8");
	end
	if (LIMIT_W < 1 || LIMIT_W > 32) begin : g_chk_limit
		$error("LIMIT_W must be 1 to 32");
	end

	typedef struct packed {
		eqm_state_t st;
		logic [LIMIT_W-1:0] timer;
		logic [LIMIT_W-1:0] limit;
		logic act;
		logic [SYNC_STAGES-1:0] sa;
		logic [SYNC_STAGES-1:0] sb;
		logic fa;
		logic fb;
		logic pa;
		logic pb;
		logic out;
		logic ready;
		logic demand;
		logic err;
		logic [15:0] diag;
		logic [31:0] rdata;
		logic rdy;
		logic slverr;
	} eqm_regs_t;

	eqm_regs_t s;
	eqm_regs_t next_s;

	logic sel_ctrl;
	logic sel_limit;
	logic sel_status;
	logic sel_diag;
	logic hi_zero;
	logic setup;
	logic wr_done;

	always_comb begin
		hi_zero = (paddr_i[ADDR_W-1:8] == '0);
		sel_ctrl = hi_zero && (paddr_i[7:0] == OFS_CTRL);
		sel_limit = hi_zero && (paddr_i[7:0] == OFS_LIMIT);
		sel_status = hi_zero && (paddr_i[7:0] == OFS_STATUS);
		sel_diag = hi_zero && (paddr_i[7:0] == OFS_DIAG);
		setup = psel_i && !penable_i;
		wr_done = psel_i && penable_i && s.rdy && pwrite_i;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		// third stage only updates the filtered view when stages 2 and 3 agree
		next_s.sa = {s.sa[SYNC_STAGES-2:0], first_contact_in_i};
		next_s.sb = {s.sb[SYNC_STAGES-2:0], second_contact_in_i};
		if (s.sa[2] == s.sa[1]) begin
			next_s.fa = s.sa[2];
		end
		if (s.sb[2] == s.sb[1]) begin
			next_s.fb = s.sb[2];
		end
		next_s.pa = s.fa;
		next_s.pb = s.fb;

		// apb: no wait state; read data is registered in the setup phase so it comes from a flip-flop
		next_s.rdy = setup;
		// misaligned addresses miss every select and answer with the error too
		next_s.slverr = setup && !(sel_ctrl || sel_limit || sel_status || sel_diag);
		if (setup) begin
			next_s.rdata = 32'h0000_0000;
			if (sel_ctrl) begin
				next_s.rdata[CTRL_ACT_BIT] = s.act;
			end
			if (sel_limit) begin
				next_s.rdata[LIMIT_W-1:0] = s.limit;
			end
			if (sel_status) begin
				next_s.rdata[STS_READY_BIT] = s.ready;
				next_s.rdata[STS_OUT_BIT] = s.out;
				next_s.rdata[STS_DEMAND_BIT] = s.demand;
				next_s.rdata[STS_ERROR_BIT] = s.err;
				next_s.rdata[STS_FIRST_BIT] = s.fa;
				next_s.rdata[STS_SECOND_BIT] = s.fb;
			end
			if (sel_diag) begin
				next_s.rdata[15:0] = s.diag;
			end
		end
		if (wr_done && sel_ctrl) begin
			next_s.act = pwdata_i[CTRL_ACT_BIT];
		end
		if (wr_done && sel_limit) begin
			next_s.limit = pwdata_i[LIMIT_W-1:0];
		end

		// monitor state machine
		if (!s.act) begin
			next_s.st = EQM_IDLE;
		end else begin
			case (s.st)
				EQM_IDLE: begin
					next_s.st = EQM_INIT;
				end
				EQM_INIT: begin
					if (s.fa && !s.fb) begin
						next_s.st = EQM_WAIT_SECOND;
						next_s.timer = s.limit;
					end else if (s.fb && !s.fa) begin
						next_s.st = EQM_WAIT_FIRST;
						next_s.timer = s.limit;
					end else if (s.fa && s.fb && !s.pa && !s.pb) begin
						// only a simultaneous closing counts, not contacts already closed
						next_s.st = EQM_ENABLED;
					end
				end
				EQM_WAIT_SECOND: begin
					// the awaited channel still counts on the edge the timer runs out
					if (!s.fa) begin
						next_s.st = EQM_INIT;
					end else if (s.fb) begin
						next_s.st = EQM_ENABLED;
					end else if (s.timer == '0) begin
						next_s.st = EQM_ERR_SECOND;
					end else begin
						next_s.timer = s.timer - 1'b1;
					end
				end
				EQM_WAIT_FIRST: begin
					if (!s.fb) begin
						next_s.st = EQM_INIT;
					end else if (s.fa) begin
						next_s.st = EQM_ENABLED;
					end else if (s.timer == '0) begin
						next_s.st = EQM_ERR_FIRST;
					end else begin
						next_s.timer = s.timer - 1'b1;
					end
				end
				EQM_ENABLED: begin
					if (!s.fa && !s.fb) begin
						next_s.st = EQM_INIT;
					end else if (!s.fa || !s.fb) begin
						next_s.st = EQM_WAIT_DROP;
						next_s.timer = s.limit;
					end
				end
				EQM_WAIT_DROP: begin
					if (!s.fa && !s.fb) begin
						next_s.st = EQM_INIT;
					end else if (s.timer == '0) begin
						next_s.st = EQM_ERR_DROP;
					end else begin
						next_s.timer = s.timer - 1'b1;
					end
				end
				EQM_ERR_SECOND, EQM_ERR_FIRST, EQM_ERR_DROP: begin
					// both contacts open is the start of a fresh sequence
					if (!s.fa && !s.fb) begin
						next_s.st = EQM_INIT;
					end
				end
				default: begin
					next_s.st = EQM_IDLE;
				end
			endcase
		end

		// outputs follow the next state so they change on the same edge
		next_s.out = (next_s.st == EQM_ENABLED);
		next_s.ready = (next_s.st != EQM_IDLE);
		next_s.demand = (next_s.st == EQM_INIT) || (next_s.st == EQM_WAIT_SECOND)
			|| (next_s.st == EQM_WAIT_FIRST) || (next_s.st == EQM_WAIT_DROP);
		next_s.err = (next_s.st == EQM_ERR_SECOND) || (next_s.st == EQM_ERR_FIRST)
			|| (next_s.st == EQM_ERR_DROP);
		case (next_s.st)
			EQM_IDLE: next_s.diag = DIAG_IDLE;
			EQM_INIT: next_s.diag = DIAG_INIT;
			EQM_ENABLED: next_s.diag = DIAG_ENABLED;
			EQM_WAIT_SECOND: next_s.diag = DIAG_WAIT_SECOND;
			EQM_WAIT_FIRST: next_s.diag = DIAG_WAIT_FIRST;
			EQM_WAIT_DROP: next_s.diag = DIAG_WAIT_DROP;
			EQM_ERR_SECOND: next_s.diag = DIAG_ERR_SECOND;
			EQM_ERR_FIRST: next_s.diag = DIAG_ERR_FIRST;
			EQM_ERR_DROP: next_s.diag = DIAG_ERR_DROP;
			default: next_s.diag = DIAG_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '0;
			s.st <= EQM_IDLE;
			s.act <= RST_ACT;
			s.limit <= LIMIT_W'(MISMATCH_CYCLES);
			s.diag <= DIAG_IDLE;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		prdata_o = s.rdata;
		pready_o = s.rdy;
		pslverr_o = s.slverr;
		combined_safe_out_o = s.out;
		ready_o = s.ready;
		safe_request_flag_o = s.demand;
		error_o = s.err;
		diagnostic_word_o = s.diag;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// outputs are registered, so most checks look one edge after the cause

	a_idle_outputs: assert property ((s.st == EQM_IDLE) |->
		(diagnostic_word_o == 16'h0000) && !ready_o && !combined_safe_out_o
		&& !safe_request_flag_o && !error_o)
		else $error("idle outputs wrong");
	a_init_outputs: assert property ((s.st == EQM_INIT) |->
		(diagnostic_word_o == 16'h8801) && ready_o && !combined_safe_out_o
		&& safe_request_flag_o && !error_o)
		else $error("init outputs wrong");
	a_enabled_outputs: assert property (combined_safe_out_o |->
		(diagnostic_word_o == 16'h8000) && ready_o && !safe_request_flag_o && !error_o
		&& $past(s.fa) && $past(s.fb))
		else $error("enabled outputs wrong");
	a_wait_second_entry: assert property ((s.st == EQM_INIT) && s.act && s.fa && !s.fb
		|=> (diagnostic_word_o == 16'h8802) && (s.timer == $past(s.limit))
		&& safe_request_flag_o && !combined_safe_out_o)
		else $error("wait for second not entered");
	a_wait_first_entry: assert property ((s.st == EQM_INIT) && s.act && s.fb && !s.fa
		|=> (diagnostic_word_o == 16'h8804) && (s.timer == $past(s.limit))
		&& safe_request_flag_o && !error_o)
		else $error("wait for first not entered");
	a_drop_wait_entry: assert property ((s.st == EQM_ENABLED) && s.act && (s.fa ^ s.fb)
		|=> (diagnostic_word_o == 16'h8806) && ready_o && safe_request_flag_o
		&& !combined_safe_out_o)
		else $error("drop wait not entered");
	a_err_second: assert property ((s.st == EQM_WAIT_SECOND) && s.act && s.fa && !s.fb
		&& (s.timer == '0) |=> (diagnostic_word_o == 16'hC010) && error_o && ready_o
		&& !safe_request_flag_o)
		else $error("second channel timeout missed");
	a_err_first: assert property ((s.st == EQM_WAIT_FIRST) && s.act && s.fb && !s.fa
		&& (s.timer == '0) |=> (diagnostic_word_o == 16'hC020) && error_o)
		else $error("first channel timeout missed");
	a_err_drop: assert property ((s.st == EQM_WAIT_DROP) && s.act && (s.fa || s.fb)
		&& (s.timer == '0) |=> (diagnostic_word_o == 16'hC030) && error_o)
		else $error("drop timeout missed");
	a_err_flags: assert property (error_o |-> !combined_safe_out_o
		&& (diagnostic_word_o[15:12] == 4'hC))
		else $error("error without forced output");
	a_drop_kills_out: assert property (combined_safe_out_o && !(s.fa && s.fb)
		|=> !combined_safe_out_o)
		else $error("output held after channel drop");
	a_deact_idle: assert property (!s.act |=> (s.st == EQM_IDLE) && !ready_o)
		else $error("deactivation ignored");
	a_err_clear: assert property (error_o && s.act && !s.fa && !s.fb
		|=> !error_o && (diagnostic_word_o == 16'h8801))
		else $error("error not cleared by fresh sequence");
	a_err_latched: assert property (error_o && s.act && (s.fa || s.fb)
		|=> error_o && $stable(diagnostic_word_o))
		else $error("error left without fresh sequence");
	a_mismatch_hold: assert property ((s.st == EQM_WAIT_SECOND) && s.act && s.fa
		&& !s.fb && (s.timer != '0) |=> !error_o && (s.timer == $past(s.timer) - 1'b1))
		else $error("early mismatch error");
	a_first_hold: assert property ((s.st == EQM_WAIT_FIRST) && s.act && s.fb && !s.fa
		&& (s.timer != '0) |=> !error_o && (s.timer == $past(s.timer) - 1'b1))
		else $error("early mismatch error waiting for first");
	a_drop_hold: assert property ((s.st == EQM_WAIT_DROP) && s.act && (s.fa || s.fb)
		&& (s.timer != '0) |=> !error_o && (s.timer == $past(s.timer) - 1'b1))
		else $error("early mismatch error waiting for drop");
	a_drop_both: assert property ((s.st == EQM_WAIT_DROP) && s.act && !s.fa && !s.fb
		|=> !error_o && (diagnostic_word_o == 16'h8801))
		else $error("symmetric drop not accepted");
	a_second_joins: assert property ((s.st == EQM_WAIT_SECOND) && s.act && s.fa && s.fb
		|=> combined_safe_out_o && (diagnostic_word_o == 16'h8000))
		else $error("late second channel not enabled");
	a_zero_limit: assert property ((s.st == EQM_ENABLED) && s.act && (s.fa ^ s.fb)
		&& (s.limit == '0) ##1 (s.act && (s.fa || s.fb)) |=> error_o)
		else $error("zero limit did not expire");

	c_enable: cover property ((s.st == EQM_WAIT_SECOND) ##1 combined_safe_out_o);
	c_first_late: cover property ((s.st == EQM_WAIT_FIRST) ##1 combined_safe_out_o);
	c_err_second: cover property ((s.st == EQM_WAIT_SECOND) ##1 (s.st == EQM_ERR_SECOND));
	c_err_drop: cover property ((s.st == EQM_WAIT_DROP) ##1 (s.st == EQM_ERR_DROP));
	c_recover: cover property (error_o ##1 (s.st == EQM_INIT));
endmodule
`default_nettype wire

// ===== test/eqmon_contacts.sv
// Purpose: behavioural pair of switch contacts feeding the monitor
// Assumes: bench commands the wanted level of each contact
// Notes: optional chatter toggles a pin for five cycles before it settles
`timescale 1ns/1ps
`default_nettype none
module eqmon_contacts (
	input wire logic clk_i, // bench clock
	input wire logic first_cmd_i, // wanted first contact level
	input wire logic second_cmd_i, // wanted second contact level
	input wire logic chatter_i, // bounce on each change
	output logic first_contact_in_o, // first contact pin
	output logic second_contact_in_o // second contact pin
);
	wire logic [1:0] cmd;
	logic [1:0] want = 2'h0;
	logic [1:0] pin = 2'h0;
	logic [2:0] cnt [2] = '{3'h0, 3'h0};

	assign cmd = {second_cmd_i, first_cmd_i};
	assign first_contact_in_o = pin[0];
	assign second_contact_in_o = pin[1];

	// real contacts bounce; the monitor's filter must ride it out
	always @(posedge clk_i) begin
		for (int i = 0; i < 2; i++) begin
			if (cmd[i] != want[i]) begin
				want[i] <= cmd[i];
				cnt[i] <= chatter_i ? 3'h5 : 3'h0;
				pin[i] <= cmd[i];
			end else if (cnt[i] != 3'h0) begin
				pin[i] <= ~pin[i];
				cnt[i] <= cnt[i] - 3'h1;
			end else begin
				pin[i] <= want[i];
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: self-checking bench of the equivalence monitor
// Assumes: APB answers in the first access cycle, without wait state; limit set in cycles
// Notes: every wait is bounded and ends the run on timeout
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
	import eqmon_pkg::*;
	localparam int LIM = 8;
	localparam logic [3:0] F_WAIT = 4'hA;
	localparam logic [3:0] F_ON = 4'hC;
	localparam logic [3:0] F_ERR = 4'h9;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic cmd_first = 1'b0;
	logic cmd_second = 1'b0;
	logic chatter = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic combined_safe_out_o;
	logic ready_o;
	logic safe_request_flag_o;
	logic error_o;
	logic [15:0] diagnostic_word_o;
	logic first_pin;
	logic second_pin;
	int n_errors = 0;
	int n_compared = 0;

	always #20 ref_clk_i = ~ref_clk_i;

	eqmon_top #(.ADDR_W(12), .LIMIT_W(24)) u_eqmon_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.first_contact_in_i(first_pin), .second_contact_in_i(second_pin), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.combined_safe_out_o(combined_safe_out_o), .ready_o(ready_o),
		.safe_request_flag_o(safe_request_flag_o), .error_o(error_o),
		.diagnostic_word_o(diagnostic_word_o));
	eqmon_contacts u_eqmon_contacts (.clk_i(ref_clk_i), .first_cmd_i(cmd_first),
		.second_cmd_i(cmd_second), .chatter_i(chatter), .first_contact_in_o(first_pin),
		.second_contact_in_o(second_pin));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic test_done;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		rd = prdata_o;
		er = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready_o !== 1'b1) begin
			n_errors++;
			$display("BAD %0t bus timeout", $time);
			test_done();
		end
	endtask

	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		`CHK(r, x)
		`CHK(e, xe)
	endtask

	task automatic st(input logic [15:0] code, input logic [3:0] f);
		logic [3:0] fl;
		fl = {ready_o, combined_safe_out_o, safe_request_flag_o, error_o};
		`CHK(diagnostic_word_o, code)
		`CHK(fl, f)
	endtask

	// contact pins pass a filter, so allow a generous bounded wait
	task automatic wait_diag(input logic [15:0] code, input logic [3:0] f);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end while (diagnostic_word_o !== code && n < 40);
		if (diagnostic_word_o !== code) begin
			n_errors++;
			$display("BAD %0t code %h never seen", $time, code);
			test_done();
		end
		st(code, f);
	endtask

	task automatic contacts(input logic a, input logic b, input logic c);
		@(posedge ref_clk_i);
		cmd_first <= a;
		cmd_second <= b;
		chatter <= c;
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		#1;
		st(DIAG_IDLE, 4'h0);
		rd_chk(12'(OFS_LIMIT), 32'h0000_0000, 1'b0);
		rd_chk(12'h010, 32'h0000_0000, 1'b1);
		wr_reg(12'(OFS_LIMIT), LIM);
		rd_chk(12'(OFS_LIMIT), LIM, 1'b0);
		wr_reg(12'(OFS_CTRL), 32'h0000_0001);
		wait_diag(DIAG_INIT, F_WAIT);
		rd_chk(12'(OFS_CTRL), 32'h0000_0001, 1'b0);
		contacts(1'b1, 1'b1, 1'b1);
		wait_diag(DIAG_ENABLED, F_ON);
		rd_chk(12'(OFS_STATUS), 32'h0000_0033, 1'b0);
		contacts(1'b0, 1'b1, 1'b0);
		wait_diag(DIAG_WAIT_DROP, F_WAIT);
		contacts(1'b0, 1'b0, 1'b0);
		wait_diag(DIAG_INIT, F_WAIT);
		contacts(1'b1, 1'b0, 1'b0);
		wait_diag(DIAG_WAIT_SECOND, F_WAIT);
		repeat (LIM) @(posedge ref_clk_i);
		#1;
		st(DIAG_WAIT_SECOND, F_WAIT);
		@(posedge ref_clk_i);
		#1;
		st(DIAG_ERR_SECOND, F_ERR);
		rd_chk(12'(OFS_DIAG), 32'h0000_C010, 1'b0);
		contacts(1'b0, 1'b0, 1'b0);
		wait_diag(DIAG_INIT, F_WAIT);
		contacts(1'b0, 1'b1, 1'b0);
		wait_diag(DIAG_WAIT_FIRST, F_WAIT);
		wait_diag(DIAG_ERR_FIRST, F_ERR);
		contacts(1'b0, 1'b0, 1'b0);
		wait_diag(DIAG_INIT, F_WAIT);
		contacts(1'b1, 1'b1, 1'b0);
		wait_diag(DIAG_ENABLED, F_ON);
		contacts(1'b1, 1'b0, 1'b0);
		wait_diag(DIAG_WAIT_DROP, F_WAIT);
		wait_diag(DIAG_ERR_DROP, F_ERR);
		contacts(1'b0, 1'b0, 1'b0);
		wait_diag(DIAG_INIT, F_WAIT);
		contacts(1'b0, 1'b1, 1'b0);
		wait_diag(DIAG_WAIT_FIRST, F_WAIT);
		repeat (2) @(posedge ref_clk_i);
		contacts(1'b1, 1'b1, 1'b0);
		wait_diag(DIAG_ENABLED, F_ON);
		contacts(1'b0, 1'b0, 1'b0);
		wait_diag(DIAG_INIT, F_WAIT);
		contacts(1'b1, 1'b0, 1'b0);
		wait_diag(DIAG_WAIT_SECOND, F_WAIT);
		contacts(1'b1, 1'b1, 1'b0);
		wait_diag(DIAG_ENABLED, F_ON);
		wr_reg(12'(OFS_CTRL), 32'h0000_0000);
		wait_diag(DIAG_IDLE, 4'h0);
		contacts(1'b0, 1'b0, 1'b0);
		wr_reg(12'(OFS_LIMIT), 32'h0000_0000);
		wr_reg(12'(OFS_CTRL), 32'h0000_0001);
		wait_diag(DIAG_INIT, F_WAIT);
		contacts(1'b1, 1'b0, 1'b0);
		wait_diag(DIAG_WAIT_SECOND, F_WAIT);
		@(posedge ref_clk_i);
		#1;
		st(DIAG_ERR_SECOND, F_ERR);
		contacts(1'b0, 1'b0, 1'b0);
		wait_diag(DIAG_INIT, F_WAIT);
		contacts(1'b1, 1'b1, 1'b0);
		wait_diag(DIAG_ENABLED, F_ON);
		contacts(1'b1, 1'b0, 1'b0);
		wait_diag(DIAG_WAIT_DROP, F_WAIT);
		@(posedge ref_clk_i);
		#1;
		st(DIAG_ERR_DROP, F_ERR);
		wr_reg(12'(OFS_CTRL), 32'h0000_0000);
		wait_diag(DIAG_IDLE, 4'h0);
		test_done();
	end
endmodule
`default_nettype wire
